// ==== design/i2c_slave_defines.svh ====
// constants for the regulator serial slave port
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH

`define SLAVE_ADDR 7'h70
`define MCODE_PREFIX 5'h01
`define BITS_PER_BYTE 4'h8
`define BYTE_IDX_ADDR 2'h0
`define BYTE_IDX_PTR 2'h1
`define BYTE_IDX_DATA 2'h2

`define ADDR_SOFTRST 8'h00
`define ADDR_VOUT 8'h01
`define ADDR_CTRL 8'h02
`define ADDR_MFR_ID 8'h40
`define ADDR_DIE_ID 8'h41

`define SOFTRST_BIT 0
`define CTRL_PT_BIT 3
`define CTRL_MODE_BIT 2
`define VOUT_RESET 7'h47
`define PT_RESET 1'b0
`define MODE_RESET 1'b0

// identification values are arbitrary
`define MFR_ID_VALUE 8'h5a
`define DIE_ID_VALUE 8'h01

`endif

// ==== design/i2c_slave_pkg.sv ====
// types shared by the regulator serial slave port
package i2c_slave_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RXBYTE = 6'h02,
        ST_ACKOUT = 6'h04,
        ST_TXBYTE = 6'h08,
        ST_ACKIN = 6'h10,
        ST_IGNORE = 6'h20
    } port_state_t;

    typedef struct packed {
        logic [6:0] voutCode;
        logic ptEnable;
        logic forcedPwm;
    } reg_cfg_t;

    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        port_state_t state;
        logic [3:0] bitCnt;
        logic [1:0] byteIdx;
        logic rw;
        logic hsArmed;
        logic hsMode;
        logic [7:0] shift;
        logic [7:0] regPtr;
        logic sdaOeN;
        reg_write_t wr;
        logic togSeen;
        logic evtPend;
        logic sclPrev;
        logic sdaPrev;
    } port_regs_t;

    typedef struct packed {
        reg_cfg_t cfg;
    } bank_regs_t;

endpackage

// ==== design/regulator_i2c_slave_port.sv ====
// two-wire serial slave port of the regulator
`timescale 1ns/1ps
`include "i2c_slave_defines.svh"
module regulator_i2c_slave_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic hsMode,
    output i2c_slave_pkg::reg_cfg_t cfg
);
    import i2c_slave_pkg::*;

    // link domain: capture each data bit on the rising serial clock
    logic linkBit_reg;
    logic linkTog_reg;

    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            linkBit_reg <= 1'b0;
            linkTog_reg <= 1'b0;
        end else begin
            linkBit_reg <= sdaIn;
            linkTog_reg <= ~linkTog_reg;
        end
    end

    logic [3:0] syncIn;
    logic [3:0] syncOut;
    logic sclS;
    logic sdaS;
    logic bitS;
    logic togS;

    assign syncIn = {scl, sdaIn, linkBit_reg, linkTog_reg};

    // scl is only ever observed, never driven
    sync_2ff #(.WIDTH(4)) u_sync (
        .clk(clk),
        .reset(reset),
        .d(syncIn),
        .q(syncOut)
    );

    assign {sclS, sdaS, bitS, togS} = syncOut;

    port_regs_t s_reg;
    port_regs_t s_next;
    logic [7:0] rdData;
    logic startDet;
    logic stopDet;
    logic sclFall;
    logic bitEvt;

    assign startDet = sclS && s_reg.sclPrev && s_reg.sdaPrev && !sdaS;
    assign stopDet = sclS && s_reg.sclPrev && !s_reg.sdaPrev && sdaS;
    assign sclFall = s_reg.sclPrev && !sclS;
    assign bitEvt = togS != s_reg.togSeen;

    regulator_register_bank u_bank (
        .clk(clk),
        .reset(reset),
        .wr(s_reg.wr),
        .rdAddr(s_reg.regPtr),
        .rdData(rdData),
        .cfg(cfg)
    );

    always_comb begin
        s_next = s_reg;
        s_next.wr.strobe = 1'b0;
        s_next.sclPrev = sclS;
        s_next.sdaPrev = sdaS;
        s_next.togSeen = togS;
        // the bit sync gets one extra cycle to settle behind the toggle
        s_next.evtPend = bitEvt;
        if (stopDet) begin
            s_next.state = ST_IDLE;
            s_next.sdaOeN = 1'b1;
            s_next.hsMode = 1'b0;
            s_next.hsArmed = 1'b0;
        end else if (startDet) begin
            // a repeated start is handled exactly like a first start
            s_next.state = ST_RXBYTE;
            s_next.bitCnt = 4'h0;
            s_next.byteIdx = `BYTE_IDX_ADDR;
            s_next.sdaOeN = 1'b1;
            if (s_reg.hsArmed) begin
                s_next.hsMode = 1'b1;
                s_next.hsArmed = 1'b0;
            end
        end else begin
            unique case (s_reg.state)
                ST_IDLE, ST_IGNORE: s_next.sdaOeN = 1'b1;
                ST_RXBYTE: begin
                    if (s_reg.evtPend && s_reg.bitCnt < `BITS_PER_BYTE) begin
                        s_next.shift = {s_reg.shift[6:0], bitS};
                        s_next.bitCnt = s_reg.bitCnt + 4'h1;
                    end
                    if (sclFall && s_reg.bitCnt == `BITS_PER_BYTE) begin
                        s_next.state = ST_ACKOUT;
                        s_next.sdaOeN = 1'b0;
                        unique case (s_reg.byteIdx)
                            `BYTE_IDX_ADDR: begin
                                if (s_reg.shift[7:1] == `SLAVE_ADDR) begin
                                    s_next.rw = s_reg.shift[0];
                                    s_next.byteIdx = `BYTE_IDX_PTR;
                                end else begin
                                    // foreign address or master code
                                    s_next.state = ST_IGNORE;
                                    s_next.sdaOeN = 1'b1;
                                    if (s_reg.shift[7:3] == `MCODE_PREFIX) begin
                                        s_next.hsArmed = 1'b1;
                                    end
                                end
                            end
                            `BYTE_IDX_PTR: begin
                                s_next.regPtr = s_reg.shift;
                                s_next.byteIdx = `BYTE_IDX_DATA;
                            end
                            default: begin
                                s_next.wr.strobe = 1'b1;
                                s_next.wr.addr = s_reg.regPtr;
                                s_next.wr.data = s_reg.shift;
                            end
                        endcase
                    end
                end
                ST_ACKOUT: begin
                    if (sclFall) begin
                        s_next.bitCnt = 4'h0;
                        if (s_reg.rw) begin
                            s_next.state = ST_TXBYTE;
                            s_next.shift = rdData;
                            s_next.sdaOeN = rdData[7];
                        end else begin
                            s_next.state = ST_RXBYTE;
                            s_next.sdaOeN = 1'b1;
                        end
                    end
                end
                ST_TXBYTE: begin
                    if (s_reg.evtPend && s_reg.bitCnt < `BITS_PER_BYTE) begin
                        s_next.bitCnt = s_reg.bitCnt + 4'h1;
                    end
                    if (sclFall) begin
                        if (s_reg.bitCnt == `BITS_PER_BYTE) begin
                            s_next.state = ST_ACKIN;
                            s_next.bitCnt = 4'h0;
                            s_next.sdaOeN = 1'b1;
                        end else begin
                            s_next.shift = {s_reg.shift[6:0], 1'b0};
                            s_next.sdaOeN = s_reg.shift[6];
                        end
                    end
                end
                ST_ACKIN: begin
                    if (s_reg.evtPend) begin
                        if (bitS) begin
                            s_next.state = ST_IGNORE;
                        end else begin
                            s_next.bitCnt = 4'h1;
                        end
                    end
                    if (sclFall && s_reg.bitCnt == 4'h1) begin
                        s_next.state = ST_TXBYTE;
                        s_next.bitCnt = 4'h0;
                        s_next.shift = rdData;
                        s_next.sdaOeN = rdData[7];
                    end
                end
                default: begin
                    s_next.state = ST_IDLE;
                    s_next.sdaOeN = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.state <= ST_IDLE;
            s_reg.sdaOeN <= 1'b1;
            // match the synchroniser's reset level so no false edge follows
            s_reg.sclPrev <= 1'b0;
            s_reg.sdaPrev <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // the driven level is always low; only the enable moves
    assign sdaOut = 1'b0;
    assign sdaOeN = s_reg.sdaOeN;
    // protocol and state machine are identical at every rate
    assign hsMode = s_reg.hsMode;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence byteEnd;
        s_reg.state == ST_RXBYTE && sclFall &&
            s_reg.bitCnt == `BITS_PER_BYTE && !startDet && !stopDet;
    endsequence

    sequence ownAddrEnd;
        byteEnd ##0 (s_reg.byteIdx == `BYTE_IDX_ADDR &&
            s_reg.shift[7:1] == `SLAVE_ADDR);
    endsequence

    sdaDriveWhen_a: assert property (!sdaOeN |->
        s_reg.state inside {ST_ACKOUT, ST_TXBYTE})
        else $error("data line pulled low outside ack or read");

    ackOwnAddr_a: assert property (ownAddrEnd |=>
        !sdaOeN && s_reg.state == ST_ACKOUT
        && s_reg.byteIdx == `BYTE_IDX_PTR)
        else $error("own address not acknowledged");

    nackForeign_a: assert property (byteEnd ##0
        (s_reg.byteIdx == `BYTE_IDX_ADDR
        && s_reg.shift[7:1] != `SLAVE_ADDR) |=> sdaOeN [*2])
        else $error("foreign address acknowledged");

    masterCodeNack_a: assert property (byteEnd ##0
        (s_reg.byteIdx == `BYTE_IDX_ADDR
        && s_reg.shift[7:3] == `MCODE_PREFIX)
        |=> sdaOeN && s_reg.hsArmed)
        else $error("master code acknowledged or not armed");

    startClears_a: assert property (startDet && !stopDet |=>
        s_reg.state == ST_RXBYTE && s_reg.bitCnt == 4'h0 && sdaOeN)
        else $error("start did not open a new packet");

    stopIdles_a: assert property (stopDet |=>
        s_reg.state == ST_IDLE && sdaOeN && !hsMode)
        else $error("stop did not end the transaction");

    hsEnter_a: assert property (startDet && !stopDet && s_reg.hsArmed
        |=> hsMode)
        else $error("high speed not entered after master code");

    hsHold_a: assert property (hsMode && !stopDet |=> hsMode)
        else $error("high speed left without a stop");

    writeStore_a: assert property (byteEnd ##0
        (s_reg.byteIdx == `BYTE_IDX_DATA && !s_reg.rw)
        |=> s_reg.wr.strobe && s_reg.wr.addr == s_reg.regPtr
        ##1 !s_reg.wr.strobe)
        else $error("data byte not stored to selected register");

    readLoad_a: assert property (s_reg.state == ST_ACKOUT && sclFall
        && s_reg.rw && !startDet && !stopDet
        |=> s_reg.state == ST_TXBYTE && s_reg.shift == $past(rdData))
        else $error("read did not load selected register");

    ptrLoad_a: assert property (byteEnd ##0
        (s_reg.byteIdx == `BYTE_IDX_PTR)
        |=> s_reg.regPtr == $past(s_reg.shift)
        && s_reg.byteIdx == `BYTE_IDX_DATA)
        else $error("pointer byte not taken");

    ackRelease_a: assert property (sclFall && !s_reg.rw
        && s_reg.state == ST_ACKOUT && !startDet && !stopDet
        |=> sdaOeN && s_reg.state == ST_RXBYTE)
        else $error("data line held after acknowledge");

    txRelease_a: assert property (sclFall
        && s_reg.state == ST_TXBYTE && s_reg.bitCnt == `BITS_PER_BYTE
        && !startDet && !stopDet |=> sdaOeN && s_reg.state == ST_ACKIN)
        else $error("data line not released for master acknowledge");

    nackEnd_a: assert property (s_reg.state == ST_ACKIN
        && s_reg.evtPend && bitS && !startDet && !stopDet
        |=> s_reg.state == ST_IGNORE && sdaOeN)
        else $error("read not ended by master not-acknowledge");

    txHold_a: assert property (s_reg.state == ST_TXBYTE && !sclFall
        && !startDet && !stopDet |=> $stable(sdaOeN))
        else $error("read data changed away from a clock fall");
endmodule

// ==== design/regulator_register_bank.sv ====
// configuration registers reached through the serial port
`timescale 1ns/1ps
`include "i2c_slave_defines.svh"
module regulator_register_bank (
    input wire logic clk,
    input wire logic reset,
    input wire i2c_slave_pkg::reg_write_t wr,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData,
    output i2c_slave_pkg::reg_cfg_t cfg
);
    import i2c_slave_pkg::*;

    bank_regs_t s_reg;
    bank_regs_t s_next;

    always_comb begin
        s_next = s_reg;
        if (wr.strobe) begin
            unique case (wr.addr)
                `ADDR_SOFTRST: begin
                    if (wr.data[`SOFTRST_BIT]) begin
                        s_next.cfg.voutCode = `VOUT_RESET;
                        s_next.cfg.ptEnable = `PT_RESET;
                        s_next.cfg.forcedPwm = `MODE_RESET;
                    end
                end
                `ADDR_VOUT: s_next.cfg.voutCode = wr.data[6:0];
                `ADDR_CTRL: begin
                    s_next.cfg.ptEnable = wr.data[`CTRL_PT_BIT];
                    s_next.cfg.forcedPwm = wr.data[`CTRL_MODE_BIT];
                end
                // identification and unmapped addresses take no write
                default: s_next = s_reg;
            endcase
        end
    end

    always_comb begin
        rdData = 8'h00;
        unique case (rdAddr)
            `ADDR_VOUT: rdData = {1'b0, s_reg.cfg.voutCode};
            `ADDR_CTRL: begin
                rdData[`CTRL_PT_BIT] = s_reg.cfg.ptEnable;
                rdData[`CTRL_MODE_BIT] = s_reg.cfg.forcedPwm;
            end
            `ADDR_MFR_ID: rdData = `MFR_ID_VALUE;
            `ADDR_DIE_ID: rdData = `DIE_ID_VALUE;
            default: rdData = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg.cfg.voutCode <= `VOUT_RESET;
            s_reg.cfg.ptEnable <= `PT_RESET;
            s_reg.cfg.forcedPwm <= `MODE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg = s_reg.cfg;

    idReadOnly_a: assert property (@(posedge clk) disable iff (reset)
        (wr.strobe && (wr.addr == `ADDR_MFR_ID || wr.addr == `ADDR_DIE_ID))
        |=> $stable(s_reg))
        else $error("write to identification register changed state");
endmodule

// ==== design/sync_2ff.sv ====
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_check
        $error("sync_2ff needs WIDTH of at least one");
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ==== sim/i2c_master_model.sv ====
// behavioural two-wire bus master that drives the serial clock
`timescale 1ns/1ps
module i2c_master_model (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    real q = 31.25;
    int clash = 0;

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // data moves while the clock is low, is sampled mid-high
    task automatic bitIo(input logic b, output logic r);
        #q sdaLow = !b;
        #q scl = 1'b1;
        #q r = sda;
        #q scl = 1'b0;
    endtask

    task automatic start();
        sdaLow = 1'b0;
        #q sdaLow = 1'b1;
        #q scl = 1'b0;
    endtask

    task automatic rstart();
        #q sdaLow = 1'b0;
        #q scl = 1'b1;
        #q sdaLow = 1'b1;
        #q scl = 1'b0;
    endtask

    // clock then stands high until the next frame
    task automatic stop();
        #q sdaLow = 1'b1;
        #q scl = 1'b1;
        #q sdaLow = 1'b0;
        #(4 * q);
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(d[i], r);
            if (r !== d[i]) clash++;
        end
        bitIo(1'b1, ack);
    endtask

    task automatic getByte(input logic ackBit, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, d[i]);
        end
        bitIo(ackBit, r);
    endtask
endmodule

// ==== sim/regulator_i2c_slave_port_tb.sv ====
// self-checking bench for the regulator serial slave port
`timescale 1ns/1ps
`include "i2c_slave_defines.svh"
module regulator_i2c_slave_port_tb;
    import i2c_slave_pkg::*;
    localparam int CYCLE_LIMIT = 60000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic scl, sdaLow, sda, sdaOut, sdaOeN, hsMode, ack;
    logic [7:0] rd;
    reg_cfg_t cfg;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    // open-drain wire with pull-up
    assign sda = (sdaLow || (!sdaOeN && !sdaOut)) ? 1'b0 : 1'b1;

    always #4 clk = ~clk;

    i2c_master_model i_master (.scl(scl), .sdaLow(sdaLow), .sda(sda));

    regulator_i2c_slave_port i_dut (
        .clk(clk),
        .reset(reset),
        .scl(scl),
        .sdaIn(sda),
        .sdaOut(sdaOut),
        .sdaOeN(sdaOeN),
        .hsMode(hsMode),
        .cfg(cfg)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want,
                         input string msg);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, want);
        end
    endtask

    task automatic summarize();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic sendAck(input logic [7:0] b, input logic want);
        i_master.sendByte(b, ack);
        check(16'(ack), 16'(want), "ack bit");
    endtask

    task automatic wrReg(input logic [7:0] ptr, input logic [7:0] d);
        i_master.start();
        sendAck(8'he0, 1'b0);
        sendAck(ptr, 1'b0);
        sendAck(d, 1'b0);
        i_master.stop();
    endtask

    task automatic rdReg(input logic [7:0] ptr, output logic [7:0] d);
        i_master.start();
        sendAck(8'he0, 1'b0);
        sendAck(ptr, 1'b0);
        i_master.rstart();
        sendAck(8'he1, 1'b0);
        i_master.getByte(1'b1, d);
        i_master.stop();
    endtask

    task automatic testReset();
        check(16'(cfg), 16'({`VOUT_RESET, `PT_RESET, `MODE_RESET}),
              "cfg reset");
        check(16'(sdaOeN), 16'h1, "idle release");
        check(16'(sdaOut), 16'h0, "driven level");
        check(16'(hsMode), 16'h0, "hs after reset");
        $display("done reset");
    endtask

    task automatic testWriteRead();
        wrReg(8'h01, 8'h55);
        check(16'(cfg.voutCode), 16'h55, "vout write");
        rdReg(8'h01, rd);
        check(16'(rd), 16'h55, "vout read");
        wrReg(8'h02, 8'h0c);
        check(16'(cfg), 16'h0157, "ctrl write");
        rdReg(8'h02, rd);
        check(16'(rd), 16'h0c, "ctrl read");
        $display("done write read");
    endtask

    task automatic testIds();
        rdReg(8'h40, rd);
        check(16'(rd), 16'(`MFR_ID_VALUE), "id read");
        wrReg(8'h40, 8'h00);
        rdReg(8'h40, rd);
        check(16'(rd), 16'(`MFR_ID_VALUE), "id read-only");
        rdReg(8'h41, rd);
        check(16'(rd), 16'(`DIE_ID_VALUE), "die read");
        rdReg(8'h10, rd);
        check(16'(rd), 16'h00, "unmapped read");
        $display("done ids");
    endtask

    task automatic testForeign();
        i_master.start();
        sendAck(8'he2, 1'b1);
        sendAck(8'h01, 1'b1);
        sendAck(8'h00, 1'b1);
        i_master.stop();
        check(16'(cfg.voutCode), 16'h55, "foreign ignored");
        $display("done foreign");
    endtask

    task automatic testHighSpeed();
        for (int c = 8; c < 16; c++) begin
            i_master.q = 260.0;
            i_master.start();
            sendAck(8'(c), 1'b1);
            i_master.q = 31.25;
            i_master.rstart();
            repeat (8) @(negedge clk);
            check(16'(hsMode), 16'h1, "hs entry");
            if (c == 15) begin
                sendAck(8'he0, 1'b0);
                sendAck(8'h01, 1'b0);
                sendAck(8'h33, 1'b0);
                i_master.rstart();
                check(16'(hsMode), 16'h1, "hs kept");
                rdReg(8'h01, rd);
                check(16'(rd), 16'h33, "hs read");
            end else begin
                i_master.stop();
            end
            check(16'(hsMode), 16'h0, "hs exit");
        end
        $display("done high speed");
    endtask

    task automatic testSoftReset();
        wrReg(8'h00, 8'h01);
        check(16'(cfg), 16'({`VOUT_RESET, `PT_RESET, `MODE_RESET}),
              "soft reset");
        rdReg(8'h00, rd);
        check(16'(rd), 16'h00, "soft reset read");
        check(16'(i_master.clash), 16'h0, "line clash");
        check(16'(sdaOeN), 16'h1, "released at end");
        $display("done soft reset");
    endtask

    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        testReset();
        testWriteRead();
        testIds();
        testForeign();
        testHighSpeed();
        testSoftReset();
        summarize();
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            failures++;
            $display("[FAIL] %0t run too long", $time);
            summarize();
        end
    end
endmodule
